// ===== dv/host_bus_model.sv
// host software model: master of the register port
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [6:0] target = 7'h00,
  output logic      [7:0] addr = 8'h00,
  output logic      [7:0] wdata = 8'h00,
  output logic            wr = 1'b0,
  output logic            rd = 1'b0
);
  // released address and data lines show the inverse of their last value; target holds
  task automatic wr_reg(input logic [6:0] t, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    target <= t;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [6:0] t, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    target <= t;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
endmodule // host_bus_model

// ===== dv/power_cmd_regs_props.sv
// checker for power_cmd_regs, bound to its ports
// assumes one clock and an async active-high reset
`timescale 1ns/1ps
`include "power_cmd_regs.vh"
module power_cmd_regs_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [6:0] target,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       cable_power,
  input wire logic       host_supply_power,
  input wire logic       safe_shutdown_req,
  input wire logic       power_off,
  input wire logic       host_reset,
  input wire logic       low_power_sleep,
  input wire logic       calibrate_req,
  input wire logic       bootloader_mode,
  input wire logic       orange_led,
  input wire logic       irq_disable,
  input wire logic       serial_enable,
  input wire logic       nvm_write,
  input wire logic [7:0] nvm_data
);
  // ----------------------------------------
  // command writes and their effects
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_reg(logic [7:0] a);
    wr && target == `TGT_CMD && addr == a;
  endsequence
  sequence s_cmd(logic [7:0] c);
    s_reg(`MODULE_COMMAND) ##0 (wdata == c && !bootloader_mode && !low_power_sleep);
  endsequence
  chk_shut_power:
    assert property (s_cmd(`CMD_SHUTDOWN) ##0 !cable_power |=> safe_shutdown_req && power_off)
    else $error("no shutdown on battery");
  chk_calib_pulse:
    assert property (s_cmd(`CMD_CALIBRATE) |=> calibrate_req)
    else $error("no calibration pulse");
  chk_boot_gate:
    assert property (s_cmd(`CMD_BOOTLOADER) |=> bootloader_mode == $past(host_supply_power))
    else $error("bootloader entry wrong");
  chk_boot_lamp:
    assert property (bootloader_mode |-> orange_led && irq_disable)
    else $error("bootloader lamp or irq off");
  chk_odd_code:
    assert property (s_reg(`MODULE_COMMAND) ##0 !(wdata inside {`CMD_SHUTDOWN, `CMD_RESTORE, `CMD_CPU_RESET,
      `CMD_CALIBRATE, `CMD_BOOTLOADER}) |=> !safe_shutdown_req && !calibrate_req)
    else $error("unknown code acted on");
  chk_alive_zero:
    assert property (s_reg(`ALIVE_COUNTDOWN) ##0 wdata == 8'h00 |=> safe_shutdown_req && host_reset)
    else $error("zero countdown no restart");
  chk_serial_cfg:
    assert property (s_reg(`SERIAL_PORT_CONFIG) ##0 wdata <= 8'h01 |=> ##1 serial_enable == $past(wdata[0], 2))
    else $error("serial enable wrong");
  chk_nvm_commit:
    assert property (s_reg(`BATTERY_RUNTIME) |=> nvm_write && nvm_data == $past(wdata))
    else $error("runtime not committed");
  chk_rtc_quiet:
    assert property (wr && target == `TGT_RTC |=> !nvm_write)
    else $error("clock write had effect");
endmodule // power_cmd_regs_props
bind power_cmd_regs power_cmd_regs_props u_props (
  .clk(clk), .rst(rst), .target(target), .addr(addr), .wdata(wdata), .wr(wr), .cable_power(cable_power),
  .host_supply_power(host_supply_power), .safe_shutdown_req(safe_shutdown_req), .power_off(power_off),
  .host_reset(host_reset), .low_power_sleep(low_power_sleep), .calibrate_req(calibrate_req),
  .bootloader_mode(bootloader_mode), .orange_led(orange_led), .irq_disable(irq_disable),
  .serial_enable(serial_enable), .nvm_write(nvm_write), .nvm_data(nvm_data)
);

// ===== dv/power_cmd_regs_test.sv
// self-checking bench for power_cmd_regs with a host bus model
// assumes the header macros and a 125 MHz clock
`timescale 1ns/1ps
`include "power_cmd_regs.vh"
module power_cmd_regs_test;
  localparam int T = 10;
  logic        clk;
  logic        rst = 1'b1;
  logic        cable_power = 1'b1;
  logic        host_supply_power = 1'b0;
  logic        function_button = 1'b0;
  logic        reset_button = 1'b0;
  logic        upload_done = 1'b0;
  logic        boot_activity = 1'b0;
  wire  [6:0]  target;
  wire  [7:0]  addr, wdata, rdata, nvm_data;
  wire         wr, rd, safe_shutdown_req, power_off, host_reset, low_power_sleep;
  wire         calibrate_req, bootloader_mode, orange_led, irq_disable, serial_enable, nvm_write;
  logic [31:0] seed = 32'h0068E617;
  logic [7:0]  d;
  int          n, fail_count, num_checks;
  logic [7:0]  rtc_exp [7] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00};
  power_cmd_regs #(.TICK_CYCLES(T)) u_dut (
    .clk(clk), .rst(rst), .target(target), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cable_power(cable_power), .host_supply_power(host_supply_power), .function_button(function_button),
    .reset_button(reset_button), .upload_done(upload_done), .boot_activity(boot_activity),
    .safe_shutdown_req(safe_shutdown_req), .power_off(power_off), .host_reset(host_reset),
    .low_power_sleep(low_power_sleep), .calibrate_req(calibrate_req), .bootloader_mode(bootloader_mode),
    .orange_led(orange_led), .irq_disable(irq_disable), .serial_enable(serial_enable),
    .nvm_write(nvm_write), .nvm_data(nvm_data)
  );
  host_bus_model h (.clk(clk), .rdata(rdata), .target(target), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int run_cycles(input int v);
    return 60 * (v + 1) * T;
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return host_reset;
      1: return low_power_sleep;
      2: return !bootloader_mode;
      default: return !low_power_sleep;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk(input logic [6:0] t, input logic [7:0] a, input logic [7:0] e);
    h.rd_reg(t, a, d);
    cmp8(d, e);
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (9000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      chk(`TGT_RTC, i[7:0], rtc_exp[i]);
    chk(`TGT_CMD, `BATTERY_RUNTIME, `RUNTIME_RST);
    chk(`TGT_CMD, `SERIAL_PORT_CONFIG, `SERIAL_RST);
    chk(`TGT_CMD, `ALIVE_COUNTDOWN, `ALIVE_RST);
    chk(`TGT_CMD, 8'h03, 8'h00);
    h.wr_reg(`TGT_RTC, `RTC_YEAR, 8'h55);
    chk(`TGT_RTC, `RTC_YEAR, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      h.wr_reg(`TGT_CMD, `BATTERY_RUNTIME, seed[7:0]);
      chk(`TGT_CMD, `BATTERY_RUNTIME, seed[7:0]);
      h.wr_reg(`TGT_CMD, `SERIAL_PORT_CONFIG, {7'h00, seed[8]});
      chk(`TGT_CMD, `SERIAL_PORT_CONFIG, {7'h00, seed[8]});
      cmp1(serial_enable, seed[8]);
      if (!(seed[23:16] inside {`CMD_SHUTDOWN, `CMD_RESTORE, `CMD_CPU_RESET, `CMD_CALIBRATE, `CMD_BOOTLOADER}))
      begin
        h.wr_reg(`TGT_CMD, `MODULE_COMMAND, seed[23:16]);
        chk(`TGT_CMD, `MODULE_COMMAND, 8'h00);
      end
    end
    h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_CALIBRATE);
    $display("random registers done");
    h.wr_reg(`TGT_CMD, `BATTERY_RUNTIME, `VAL_DISABLED);
    for (int p = 0; p < 2; p++)
    begin
      cable_power <= (p == 0);
      h.wr_reg(`TGT_CMD, `ALIVE_COUNTDOWN, 8'h03);
      h.rd_reg(`TGT_CMD, `ALIVE_COUNTDOWN, d);
      cmp1(d == 8'h03 || d == 8'h02, 1'b1);
      wait_for(0, 6 * T);
      cmp1(n >= 2 * T - 4 && n <= 3 * T + 2, 1'b1);
      chk(`TGT_CMD, `ALIVE_COUNTDOWN, `VAL_DISABLED);
    end
    for (int r = 0; r < 3; r++)
    begin
      h.wr_reg(`TGT_CMD, `ALIVE_COUNTDOWN, 8'h03);
      wait_for(0, 3 * T / 2);
      cmp1(n == 3 * T / 2, 1'b1);
    end
    h.wr_reg(`TGT_CMD, `ALIVE_COUNTDOWN, `VAL_DISABLED);
    chk(`TGT_CMD, `ALIVE_COUNTDOWN, `VAL_DISABLED);
    h.wr_reg(`TGT_CMD, `ALIVE_COUNTDOWN, 8'h00);
    chk(`TGT_CMD, `ALIVE_COUNTDOWN, `VAL_DISABLED);
    repeat (62 * T) @(posedge clk);
    cmp1(low_power_sleep, 1'b0);
    cable_power <= 1'b1;
    $display("alive countdown done");
    h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_RESTORE);
    chk(`TGT_CMD, `MODULE_COMMAND, `CMD_RESTORE);
    repeat (20) @(posedge clk);
    chk(`TGT_CMD, `MODULE_COMMAND, 8'h00);
    chk(`TGT_CMD, `BATTERY_RUNTIME, `RUNTIME_RST);
    cable_power <= 1'b0;
    wait_for(1, run_cycles(0) + 2 * T);
    cmp1(n >= run_cycles(0) - T && n <= run_cycles(0) + T, 1'b1);
    cmp1(power_off, 1'b1);
    cable_power <= 1'b1;
    wait_for(3, 4 * T);
    cmp1(n < 4 * T, 1'b1);
    cable_power <= 1'b0;
    wait_for(1, run_cycles(0) + 2 * T);
    function_button <= 1'b1;
    repeat (T) @(posedge clk);
    function_button <= 1'b0;
    repeat (2 * T) @(posedge clk);
    cmp1(low_power_sleep, 1'b1);
    function_button <= 1'b1;
    wait_for(3, 5 * T);
    function_button <= 1'b0;
    cmp1(n >= 2 * T && n <= 4 * T, 1'b1);
    wait_for(1, run_cycles(0) + 2 * T);
    cmp1(n >= run_cycles(0) - T && n <= run_cycles(0) + T, 1'b1);
    cable_power <= 1'b1;
    wait_for(3, 4 * T);
    $display("battery run time done");
    h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_CPU_RESET);
    chk(`TGT_RTC, `RTC_MINUTES, 8'h00);
    h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_BOOTLOADER);
    repeat (2) @(posedge clk);
    cmp1(bootloader_mode, 1'b0);
    host_supply_power <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_BOOTLOADER);
      repeat (2) @(posedge clk);
      cmp1(orange_led, 1'b1);
      reset_button <= (m == 1);
      upload_done <= (m == 2);
      boot_activity <= (m == 0);
      repeat (m == 0 ? 3 * T : 1) @(posedge clk);
      reset_button <= 1'b0;
      upload_done <= 1'b0;
      boot_activity <= 1'b0;
      wait_for(2, 18 * T);
      cmp1(m == 0 ? (n >= 15 * T && n <= 17 * T) : (n < 4), 1'b1);
      chk(`TGT_RTC, `RTC_DAY_OF_MONTH, 8'h01);
    end
    $display("bootloader done");
    cable_power <= 1'b0;
    h.wr_reg(`TGT_CMD, `MODULE_COMMAND, `CMD_SHUTDOWN);
    repeat (2) @(posedge clk);
    cmp1(power_off, 1'b1);
    $display("shutdown done");
    end_sim;
  end
endmodule // power_cmd_regs_test

// ===== logic/power_cmd_regs.v
// power module command interpreter with calendar clock mirror
// assumes a synchronous register port, one clock, and power status inputs
// What this block does
// - clock registers and command registers sit at two distinct targets
// - seven read-only BCD clock fields at offsets 0x00 to 0x06
// - shutdown code runs safe shutdown, removes power when on battery
// - restore code restores defaults; reads back code until done, then zero
// - cpu-reset code reloads start-up values, clock set to 2000-01-01
// - calibration code trims converters; host uses it only when charged
// - bootloader code enters load mode; exits on button, upload, 16 s idle
// - bootloader refused unless powered through the host supply input
// - cable lost and run time expired: safe shutdown, battery off, sleep
// - in sleep after timeout, cable power return restarts host
// - in sleep, function button held over 2 s restarts host
// - run time value 0xff disables the limit
// - run time is 60 s plus 60 s per unit up to 0xfe
// - after timeout shutdown a button hold over 2 s restarts and rearms run time
// - run time write commits to nonvolatile storage; reads show value
// - serial config zero disables port, one enables at 115200
// - alive countdown readable anytime; 0xff disables, default
// - 0x01..0xfe enables countdown per second; zero forces host reset
// - writing zero to countdown pulses safe shutdown and host reset in the same cycle
// - countdown works the same on battery or cable power
// - after countdown restart the register reloads 0xff
// - writes to mirror registers have no lasting effect
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "power_cmd_regs.vh"
module power_cmd_regs #(
  parameter TICK_CYCLES = `CLK_HZ,
  parameter RESTORE_CYCLES = 16
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [6:0] target,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  input  wire       cable_power,
  input  wire       host_supply_power,
  input  wire       function_button,
  input  wire       reset_button,
  input  wire       upload_done,
  input  wire       boot_activity,
  output reg        safe_shutdown_req,
  output reg        power_off,
  output reg        host_reset,
  output reg        low_power_sleep,
  output reg        calibrate_req,
  output reg        bootloader_mode,
  output reg        orange_led,
  output reg        irq_disable,
  output reg        serial_enable,
  output reg        nvm_write,
  output reg  [7:0] nvm_data
);

// ---------------------------------------------
// helpers
// ---------------------------------------------
function [7:0] bcd_inc;
  input [7:0] v;
  begin
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  end
endfunction

function [31:0] secs_for;
  input [7:0] v;
  begin
    secs_for = `MINUTE_S + `MINUTE_S * {24'h000000, v};
  end
endfunction

function [7:0] days_in;
  input [7:0] m;
  input [7:0] y;
  begin
    case (m)
      8'h02:   days_in = (y[1:0] == 2'h0 && y[4] == 1'b0) || (y[1:0] == 2'h2 && y[4] == 1'b1) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default: days_in = 8'h31;
    endcase
  end
endfunction

// ---------------------------------------------
// one second tick
// ---------------------------------------------
reg  [31:0] tick_cnt_reg;
wire        tick = (tick_cnt_reg == TICK_CYCLES - 1);

always @(posedge clk or posedge rst)
begin
  if (rst)
    tick_cnt_reg <= 32'h00000000;
  else if (tick)
    tick_cnt_reg <= 32'h00000000;
  else
    tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
end

// ---------------------------------------------
// register strobes
// ---------------------------------------------
wire cmd_wr = wr && target == `TGT_CMD;
wire wr_cmd = cmd_wr && addr == `MODULE_COMMAND;
wire wr_run = cmd_wr && addr == `BATTERY_RUNTIME;
wire wr_ser = cmd_wr && addr == `SERIAL_PORT_CONFIG;
wire wr_alv = cmd_wr && addr == `ALIVE_COUNTDOWN;

// ---------------------------------------------
// supervision states
// ---------------------------------------------
localparam ST_RUN   = 5'b00001;
localparam ST_BOOT  = 5'b00010;
localparam ST_REST  = 5'b00100;
localparam ST_SLEEP = 5'b01000;
localparam ST_CPU   = 5'b10000;

reg  [4:0]  state_reg;
reg  [7:0]  command_reg;
reg  [7:0]  runtime_reg;
reg  [7:0]  serial_reg;
reg  [7:0]  alive_reg;
reg  [31:0] bat_secs_reg;
reg  [4:0]  boot_idle_reg;
reg  [1:0]  hold_reg;
reg  [7:0]  restore_reg;
reg  [7:0]  sec_reg, min_reg, hour_reg, wday_reg, mday_reg, mon_reg, year_reg;

wire alive_expire = tick && alive_reg == 8'h01;
wire bat_expire   = !cable_power && runtime_reg != `VAL_DISABLED &&
                    bat_secs_reg >= secs_for(runtime_reg);

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    state_reg         <= ST_RUN;
    command_reg       <= 8'h00;
    runtime_reg       <= `RUNTIME_RST;
    serial_reg        <= `SERIAL_RST;
    alive_reg         <= `ALIVE_RST;
    bat_secs_reg      <= 32'h00000000;
    boot_idle_reg     <= 5'h00;
    hold_reg          <= 2'h0;
    restore_reg       <= 8'h00;
    safe_shutdown_req <= 1'b0;
    power_off         <= 1'b0;
    host_reset        <= 1'b0;
    low_power_sleep   <= 1'b0;
    calibrate_req     <= 1'b0;
    bootloader_mode   <= 1'b0;
    orange_led        <= 1'b0;
    irq_disable       <= 1'b0;
    nvm_write         <= 1'b0;
    nvm_data          <= 8'h00;
  end
  else
  begin
    safe_shutdown_req <= 1'b0;
    host_reset        <= 1'b0;
    calibrate_req     <= 1'b0;
    nvm_write         <= 1'b0;
    if (wr_ser)
      serial_reg <= wdata;
    if (wr_run)
    begin
      runtime_reg <= wdata;
      nvm_write   <= 1'b1;
      nvm_data    <= wdata;
    end
    // battery run time counter
    if (cable_power)
      bat_secs_reg <= 32'h00000000;
    else if (tick && state_reg == ST_RUN)
      bat_secs_reg <= bat_secs_reg + 32'h00000001;
    // alive countdown, same on either supply
    if (wr_alv)
    begin
      alive_reg <= wdata;
      if (wdata == 8'h00)
      begin
        safe_shutdown_req <= 1'b1;
        host_reset        <= 1'b1;
        alive_reg         <= `VAL_DISABLED;
      end
    end
    else if (alive_expire)
    begin
      host_reset <= 1'b1;
      alive_reg  <= `VAL_DISABLED;
    end
    else if (tick && alive_reg != `VAL_DISABLED && alive_reg != 8'h00)
      alive_reg <= alive_reg - 8'h01;
    case (state_reg)
      ST_RUN:
      begin
        if (bat_expire)
        begin
          safe_shutdown_req <= 1'b1;
          power_off         <= 1'b1;
          low_power_sleep   <= 1'b1;
          hold_reg          <= 2'h0;
          state_reg         <= ST_SLEEP;
        end
        else if (wr_cmd)
        begin
          case (wdata)
            `CMD_SHUTDOWN:
            begin
              safe_shutdown_req <= 1'b1;
              power_off         <= !cable_power;
            end
            `CMD_RESTORE:
            begin
              command_reg <= `CMD_RESTORE;
              restore_reg <= 8'h00;
              state_reg   <= ST_REST;
            end
            `CMD_CPU_RESET:
              state_reg <= ST_CPU;
            `CMD_CALIBRATE:
              calibrate_req <= 1'b1;
            `CMD_BOOTLOADER:
              if (host_supply_power)
              begin
                bootloader_mode <= 1'b1;
                orange_led      <= 1'b1;
                irq_disable     <= 1'b1;
                boot_idle_reg   <= 5'h00;
                state_reg       <= ST_BOOT;
              end
            default:
              state_reg <= ST_RUN;
          endcase
        end
      end
      ST_BOOT:
      begin
        if (boot_activity)
          boot_idle_reg <= 5'h00;
        else if (tick)
          boot_idle_reg <= boot_idle_reg + 5'h01;
        if (reset_button || upload_done || boot_idle_reg >= `BOOT_IDLE_S)
          state_reg <= ST_CPU;
      end
      ST_REST:
      begin
        restore_reg <= restore_reg + 8'h01;
        if (restore_reg == RESTORE_CYCLES - 1)
        begin
          runtime_reg <= `RUNTIME_RST;
          serial_reg  <= `SERIAL_RST;
          alive_reg   <= `ALIVE_RST;
          nvm_write   <= 1'b1;
          nvm_data    <= `RUNTIME_RST;
          command_reg <= 8'h00;
          state_reg   <= ST_RUN;
        end
      end
      ST_SLEEP:
      begin
        if (!function_button)
          hold_reg <= 2'h0;
        else if (tick && hold_reg != 2'h3)
          hold_reg <= hold_reg + 2'h1;
        if (cable_power || hold_reg > `BUTTON_HOLD_S)
        begin
          power_off       <= 1'b0;
          low_power_sleep <= 1'b0;
          host_reset      <= 1'b1;
          bat_secs_reg    <= 32'h00000000;
          state_reg       <= ST_RUN;
        end
      end
      ST_CPU:
      begin
        bootloader_mode <= 1'b0;
        orange_led      <= 1'b0;
        irq_disable     <= 1'b0;
        command_reg     <= 8'h00;
        state_reg       <= ST_RUN;
      end
      default:
        state_reg <= ST_RUN;
    endcase
  end
end

// ---------------------------------------------
// calendar clock
// ---------------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    sec_reg  <= 8'h00;
    min_reg  <= 8'h00;
    hour_reg <= 8'h00;
    wday_reg <= 8'h06;
    mday_reg <= 8'h01;
    mon_reg  <= 8'h01;
    year_reg <= 8'h00;
  end
  else if (state_reg == ST_CPU)
  begin
    sec_reg  <= 8'h00;
    min_reg  <= 8'h00;
    hour_reg <= 8'h00;
    wday_reg <= 8'h06;
    mday_reg <= 8'h01;
    mon_reg  <= 8'h01;
    year_reg <= 8'h00;
  end
  else if (tick)
  begin
    sec_reg <= (sec_reg == 8'h59) ? 8'h00 : bcd_inc(sec_reg);
    if (sec_reg == 8'h59)
    begin
      min_reg <= (min_reg == 8'h59) ? 8'h00 : bcd_inc(min_reg);
      if (min_reg == 8'h59)
      begin
        hour_reg <= (hour_reg == 8'h23) ? 8'h00 : bcd_inc(hour_reg);
        if (hour_reg == 8'h23)
        begin
          wday_reg <= (wday_reg == 8'h07) ? 8'h01 : bcd_inc(wday_reg);
          mday_reg <= (mday_reg == days_in(mon_reg, year_reg)) ? 8'h01 : bcd_inc(mday_reg);
          if (mday_reg == days_in(mon_reg, year_reg))
          begin
            mon_reg <= (mon_reg == 8'h12) ? 8'h01 : bcd_inc(mon_reg);
            if (mon_reg == 8'h12)
              year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
          end
        end
      end
    end
  end
end

// ---------------------------------------------
// read port, mirrors ignore writes
// ---------------------------------------------
always @(posedge clk or posedge rst)
begin
  if (rst)
    rdata <= 8'h00;
  else if (rd && target == `TGT_RTC)
    case (addr)
      `RTC_SECONDS:      rdata <= sec_reg;
      `RTC_MINUTES:      rdata <= min_reg;
      `RTC_HOURS:        rdata <= hour_reg;
      `RTC_WEEKDAY:      rdata <= wday_reg;
      `RTC_DAY_OF_MONTH: rdata <= mday_reg;
      `RTC_MONTH:        rdata <= mon_reg;
      `RTC_YEAR:         rdata <= year_reg;
      default:           rdata <= 8'h00;
    endcase
  else if (rd && target == `TGT_CMD)
    case (addr)
      `MODULE_COMMAND:     rdata <= command_reg;
      `BATTERY_RUNTIME:    rdata <= runtime_reg;
      `SERIAL_PORT_CONFIG: rdata <= serial_reg;
      `ALIVE_COUNTDOWN:    rdata <= alive_reg;
      default:             rdata <= 8'h00;
    endcase
  else
    rdata <= 8'h00;
end

always @(posedge clk or posedge rst)
begin
  if (rst)
    serial_enable <= 1'b0;
  else
    serial_enable <= serial_reg == `SERIAL_ON;
end

endmodule // power_cmd_regs

// ===== logic/power_cmd_regs.vh
// constants for the power module command and clock register block
// included by power_cmd_regs.v; definitions only
`ifndef POWER_CMD_REGS_VH
`define POWER_CMD_REGS_VH
// target selects
`define TGT_RTC            7'h6A
`define TGT_CMD            7'h6B
// clock field offsets
`define RTC_SECONDS        8'h00
`define RTC_MINUTES        8'h01
`define RTC_HOURS          8'h02
`define RTC_WEEKDAY        8'h03
`define RTC_DAY_OF_MONTH   8'h04
`define RTC_MONTH          8'h05
`define RTC_YEAR           8'h06
// command register offsets
`define MODULE_COMMAND     8'h00
`define BATTERY_RUNTIME    8'h01
`define SERIAL_PORT_CONFIG 8'h02
`define ALIVE_COUNTDOWN    8'h05
// command codes
`define CMD_SHUTDOWN       8'hCC
`define CMD_RESTORE        8'hDD
`define CMD_CPU_RESET      8'hEE
`define CMD_CALIBRATE      8'h11
`define CMD_BOOTLOADER     8'hFF
// values
`define VAL_DISABLED       8'hFF
`define VAL_MAX_RUNTIME    8'hFE
`define SERIAL_RST         8'h00
`define SERIAL_ON          8'h01
`define ALIVE_RST          8'hFF
`define RUNTIME_RST        8'h00
// timing
`define CLK_HZ             125000000
`define BOOT_IDLE_S        16
`define BUTTON_HOLD_S      2
`define MINUTE_S           60
`endif
